// ---- rtl/gpdg_map.svh ----
`ifndef GPDG_MAP_SVH
`define GPDG_MAP_SVH
// Short I/O window and its data-space shift
`define GPDG_IO_LAST       6'h3f
`define GPDG_IO_TO_DS      16'h0020
`define GPDG_EXT_BASE      16'h0060
// Data-space addresses of the port registers
`define GPDG_DS_IN_F       16'h0020
`define GPDG_DS_IN_E       16'h0021
`define GPDG_DS_DIR_E      16'h0022
`define GPDG_DS_OUT_E      16'h0023
`define GPDG_DS_IN_D       16'h0030
`define GPDG_DS_DIR_F      16'h0061
`define GPDG_DS_OUT_F      16'h0062
`define GPDG_DS_IN_G       16'h0063
`define GPDG_DS_DIR_G      16'h0064
`define GPDG_DS_OUT_G      16'h0065
// Short I/O offsets of the low-range registers
`define GPDG_IO_IN_F       6'h00
`define GPDG_IO_IN_E       6'h01
`define GPDG_IO_DIR_E      6'h02
`define GPDG_IO_OUT_E      6'h03
`define GPDG_IO_IN_D       6'h10
// Reset values and port G width
`define GPDG_RST8          8'h00
`define GPDG_RST5          5'h00
`define GPDG_G_UNUSED      3'h0
`define GPDG_READ_NONE     8'h00
`endif

// ---- rtl/gpdg_pkg.sv ----
package gpdg_pkg;
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [5:0]  addr;
      logic [7:0]  wdata;
   } gpdg_io_req_type;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } gpdg_ds_req_type;

   typedef struct packed {
      logic [7:0] out_e;
      logic [7:0] dir_e;
      logic [7:0] out_f;
      logic [7:0] dir_f;
      logic [4:0] out_g;
      logic [4:0] dir_g;
      logic [7:0] smp_d;
      logic [7:0] smp_e;
      logic [7:0] smp_f;
      logic [4:0] smp_g;
      logic [7:0] oe_e;
      logic [7:0] oe_f;
      logic [4:0] oe_g;
      logic [7:0] rdata;
      logic       rvalid;
   } gpdg_state_type;
endpackage

// ---- rtl/gpdg_port_regs.sv ----
`timescale 1ns/1ps
`include "gpdg_map.svh"
module gpdg_port_regs (
   // Clock, reset, enable
   input  wire logic                     clock,
   input  wire logic                     rst,
   input  wire logic                     ce,
   // Legacy compatibility mode
   input  wire logic                     compat_mode,
   // Register access paths
   input  wire gpdg_pkg::gpdg_io_req_type io_req,
   input  wire gpdg_pkg::gpdg_ds_req_type ds_req,
   output logic [7:0]                    rdata,
   output logic                          rvalid,
   // Port pins
   input  wire logic [7:0]               port_d_in,
   input  wire logic [7:0]               port_e_in,
   output logic [7:0]                    port_e_out,
   output logic [7:0]                    port_e_oe,
   input  wire logic [7:0]               port_f_in,
   output logic [7:0]                    port_f_out,
   output logic [7:0]                    port_f_oe,
   input  wire logic [4:0]               port_g_in,
   output logic [4:0]                    port_g_out,
   output logic [4:0]                    port_g_oe
);
   import gpdg_pkg::*;

   gpdg_state_type st;
   gpdg_state_type next_st;
   logic           acc_rd;
   logic           acc_wr;
   logic [15:0]    acc_addr;
   logic [7:0]     acc_wdata;
   logic [7:0]     rd_val;

   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      // Pins sampled every cycle with ce high, regardless of direction
      next_st.smp_d = port_d_in;
      next_st.smp_e = port_e_in;
      next_st.smp_f = port_f_in;
      next_st.smp_g = port_g_in;
      // Data-space path wins when both paths ask in one cycle
      if (ds_req.rd || ds_req.wr) begin
         acc_rd    = ds_req.rd;
         acc_wr    = ds_req.wr;
         acc_addr  = ds_req.addr;
         acc_wdata = ds_req.wdata;
      end else begin
         acc_rd    = io_req.rd;
         acc_wr    = io_req.wr;
         // Short I/O offset shifted into data space; 0x3f+0x20 stays below 0x60
         acc_addr  = {10'h000, io_req.addr} + `GPDG_IO_TO_DS;
         acc_wdata = io_req.wdata;
      end
      // Writes
      if (acc_wr) begin
         if (acc_addr == `GPDG_DS_DIR_E) begin
            next_st.dir_e = acc_wdata;
         end else if (acc_addr == `GPDG_DS_OUT_E) begin
            next_st.out_e = acc_wdata;
         end else if (acc_addr == `GPDG_DS_DIR_F && !compat_mode) begin
            next_st.dir_f = acc_wdata;
         end else if (acc_addr == `GPDG_DS_OUT_F && !compat_mode) begin
            next_st.out_f = acc_wdata;
         end else if (acc_addr == `GPDG_DS_DIR_G && !compat_mode) begin
            next_st.dir_g = acc_wdata[4:0];
         end else if (acc_addr == `GPDG_DS_OUT_G && !compat_mode) begin
            next_st.out_g = acc_wdata[4:0];
         end
      end
      // Reads
      if (acc_addr == `GPDG_DS_IN_F) begin
         rd_val = st.smp_f;
      end else if (acc_addr == `GPDG_DS_IN_E) begin
         rd_val = st.smp_e;
      end else if (acc_addr == `GPDG_DS_DIR_E) begin
         rd_val = st.dir_e;
      end else if (acc_addr == `GPDG_DS_OUT_E) begin
         rd_val = st.out_e;
      end else if (acc_addr == `GPDG_DS_IN_D) begin
         rd_val = st.smp_d;
      end else if (acc_addr == `GPDG_DS_DIR_F && !compat_mode) begin
         rd_val = st.dir_f;
      end else if (acc_addr == `GPDG_DS_OUT_F && !compat_mode) begin
         rd_val = st.out_f;
      end else if (acc_addr == `GPDG_DS_IN_G) begin
         rd_val = {`GPDG_G_UNUSED, st.smp_g};
      end else if (acc_addr == `GPDG_DS_DIR_G && !compat_mode) begin
         rd_val = {`GPDG_G_UNUSED, st.dir_g};
      end else if (acc_addr == `GPDG_DS_OUT_G && !compat_mode) begin
         rd_val = {`GPDG_G_UNUSED, st.out_g};
      end else begin
         rd_val = `GPDG_READ_NONE;
      end
      if (acc_rd) begin
         next_st.rdata  = rd_val;
         next_st.rvalid = 1'b1;
      end
      // Pin drive follows the new direction values; ports F and G are not driven in legacy mode
      next_st.oe_e = next_st.dir_e;
      next_st.oe_f = compat_mode ? `GPDG_RST8 : next_st.dir_f;
      next_st.oe_g = compat_mode ? `GPDG_RST5 : next_st.dir_g;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign rdata      = st.rdata;
   assign rvalid     = st.rvalid;
   assign port_e_out = st.out_e;
   assign port_e_oe  = st.oe_e;
   assign port_f_out = st.out_f;
   assign port_f_oe  = st.oe_f;
   assign port_g_out = st.out_g;
   assign port_g_oe  = st.oe_g;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   logic ds_idle;
   assign ds_idle = !ds_req.rd && !ds_req.wr;

   property p_io_read_e;
      ce && ds_idle && io_req.rd && io_req.addr == `GPDG_IO_OUT_E |=> rvalid && rdata == $past(port_e_out);
   endproperty
   a_io_read_e: assert property (p_io_read_e) else $error("short I/O read of port E data wrong");

   property p_ds_read_e;
      ce && ds_req.rd && ds_req.addr == `GPDG_DS_DIR_E |=> rvalid && rdata == $past(port_e_oe);
   endproperty
   a_ds_read_e: assert property (p_ds_read_e) else $error("data-space read of port E direction wrong");

   property p_io_no_ext;
      ce && ds_idle && io_req.wr && !$past(rst) |=> $stable(port_f_out) && $stable(port_g_out);
   endproperty
   a_io_no_ext: assert property (p_io_no_ext) else $error("short I/O write reached extended space");

   property p_write_out_f;
      ce && !compat_mode && ds_req.wr && ds_req.addr == `GPDG_DS_OUT_F |=> port_f_out == $past(ds_req.wdata);
   endproperty
   a_write_out_f: assert property (p_write_out_f) else $error("port F data write lost");

   property p_write_dir_e;
      ce && ds_req.wr && ds_req.addr == `GPDG_DS_DIR_E |=> port_e_oe == $past(ds_req.wdata);
   endproperty
   a_write_dir_e: assert property (p_write_dir_e) else $error("port E direction write lost");

   property p_read_pin_f;
      ce && $past(ce) && !$past(rst) && ds_req.rd && ds_req.addr == `GPDG_DS_IN_F
         |=> rdata == $past(port_f_in, 2);
   endproperty
   a_read_pin_f: assert property (p_read_pin_f) else $error("port F pin level read wrong");

   property p_g_upper;
      ce && ds_req.rd && ds_req.addr == `GPDG_DS_OUT_G |=> rdata[7:5] == `GPDG_G_UNUSED;
   endproperty
   a_g_upper: assert property (p_g_upper) else $error("port G upper bits not zero");

   property p_read_pin_g;
      ce && $past(ce) && !$past(rst) && ds_req.rd && ds_req.addr == `GPDG_DS_IN_G
         |=> rdata[4:0] == $past(port_g_in, 2);
   endproperty
   a_read_pin_g: assert property (p_read_pin_g) else $error("port G pin level read wrong");

   property p_compat_f;
      ce && compat_mode |=> port_f_oe == `GPDG_RST8;
   endproperty
   a_compat_f: assert property (p_compat_f) else $error("port F driven in legacy mode");

   property p_compat_g;
      ce && compat_mode |=> port_g_oe == `GPDG_RST5 && $stable(port_g_out);
   endproperty
   a_compat_g: assert property (p_compat_g) else $error("port G active in legacy mode");

   property p_write_out_g;
      ce && !compat_mode && ds_req.wr && ds_req.addr == `GPDG_DS_OUT_G |=> port_g_out == $past(ds_req.wdata[4:0]);
   endproperty
   a_write_out_g: assert property (p_write_out_g) else $error("port G data write lost");

   property p_write_dir_g;
      ce && !compat_mode && ds_req.wr && ds_req.addr == `GPDG_DS_DIR_G |=> port_g_oe == $past(ds_req.wdata[4:0]);
   endproperty
   a_write_dir_g: assert property (p_write_dir_g) else $error("port G direction write lost");

   property p_compat_drop_f;
      ce && compat_mode && ds_req.wr && ds_req.addr == `GPDG_DS_OUT_F |=> $stable(port_f_out);
   endproperty
   a_compat_drop_f: assert property (p_compat_drop_f) else $error("port F data written in legacy mode");

   property p_compat_hide_f;
      ce && compat_mode && ds_req.rd && ds_req.addr == `GPDG_DS_DIR_F |=> rdata == `GPDG_READ_NONE;
   endproperty
   a_compat_hide_f: assert property (p_compat_hide_f) else $error("port F direction visible in legacy mode");

   property p_rvalid_pulse;
      ce && !ds_req.rd && !io_req.rd |=> !rvalid;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without a read");

   c_io_write: cover property (ce && ds_idle && io_req.wr && io_req.addr == `GPDG_IO_OUT_E);
   c_ext_write: cover property (ce && ds_req.wr && ds_req.addr == `GPDG_DS_DIR_G);
   c_compat_read: cover property (ce && compat_mode && ds_req.rd && ds_req.addr == `GPDG_DS_OUT_F);
   c_pin_read: cover property (ce && ds_req.rd && ds_req.addr == `GPDG_DS_IN_G);
   c_ce_hold: cover property (!ce && ds_req.wr);
endmodule

// ---- tb/gpdg_testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import gpdg_pkg::*;
   logic            clock       = 1'b0;
   logic            rst         = 1'b1;
   logic            ce          = 1'b1;
   logic            compat_mode = 1'b0;
   gpdg_io_req_type io_req      = '0;
   gpdg_ds_req_type ds_req      = '0;
   logic [7:0]      port_d_in   = 8'h00;
   logic [7:0]      port_e_in   = 8'h00;
   logic [7:0]      port_f_in   = 8'h00;
   logic [4:0]      port_g_in   = 5'h00;
   logic [7:0]      rdata, port_e_out, port_e_oe, port_f_out, port_f_oe;
   logic [4:0]      port_g_out, port_g_oe;
   logic            rvalid;
   int              error_cnt   = 0;
   int              n_compared  = 0;
   logic [15:0]     rw [6]      = '{16'h0022, 16'h0023, 16'h0061, 16'h0062, 16'h0064, 16'h0065};

   always #2 clock = ~clock;

   gpdg_port_regs dut (
      .clock(clock), .rst(rst), .ce(ce), .compat_mode(compat_mode),
      .io_req(io_req), .ds_req(ds_req), .rdata(rdata), .rvalid(rvalid),
      .port_d_in(port_d_in), .port_e_in(port_e_in), .port_e_out(port_e_out), .port_e_oe(port_e_oe),
      .port_f_in(port_f_in), .port_f_out(port_f_out), .port_f_oe(port_f_oe),
      .port_g_in(port_g_in), .port_g_out(port_g_out), .port_g_oe(port_g_oe));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One access: drive after an edge, taken at the next edge, then released
   task automatic req(input logic ds, input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      if (ds) ds_req = '{rd: !wr, wr: wr, addr: a, wdata: d};
      else io_req = '{rd: !wr, wr: wr, addr: a[5:0], wdata: d};
      @(posedge clock);
      #1;
      ds_req = '0;
      io_req = '0;
   endtask

   task automatic rd(input logic ds, input logic [15:0] a, input logic [7:0] exp);
      req(ds, 1'b0, a, 8'h00);
      chk({7'h00, rvalid}, 8'h01);
      chk(rdata, exp);
   endtask

   task automatic do_reset();
      rst = 1'b1;
      repeat (12) @(posedge clock);
      #1;
      rst = 1'b0;
   endtask

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #20000;
      error_cnt++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      summarize();
   end

   initial begin
      do_reset();
      foreach (rw[i]) rd(1'b1, rw[i], 8'h00);
      chk(port_e_oe | port_f_oe | {3'h0, port_g_oe}, 8'h00);
      $display("test reset values done");
      req(1'b1, 1'b1, 16'h0023, 8'ha5);
      chk(port_e_out, 8'ha5);
      req(1'b0, 1'b1, 16'h0002, 8'h3c);
      chk(port_e_oe, 8'h3c);
      rd(1'b0, 16'h0003, 8'ha5);
      rd(1'b1, 16'h0022, 8'h3c);
      req(1'b1, 1'b1, 16'h0003, 8'h11);
      chk(port_e_out, 8'ha5);
      chk({7'h00, rvalid}, 8'h00);
      rd(1'b0, 16'h0022, 8'h00);
      ce = 1'b0;
      req(1'b1, 1'b1, 16'h0023, 8'h5a);
      chk(port_e_out, 8'ha5);
      ce = 1'b1;
      $display("test port e access done");
      req(1'b1, 1'b1, 16'h0061, 8'hff);
      req(1'b1, 1'b1, 16'h0062, 8'hc3);
      req(1'b1, 1'b1, 16'h0064, 8'hff);
      req(1'b1, 1'b1, 16'h0065, 8'hea);
      rd(1'b1, 16'h0062, 8'hc3);
      rd(1'b1, 16'h0064, 8'h1f);
      rd(1'b1, 16'h0065, 8'h0a);
      chk(port_f_oe, 8'hff);
      chk(port_f_out, 8'hc3);
      chk({3'h0, port_g_oe}, 8'h1f);
      chk({3'h0, port_g_out}, 8'h0a);
      req(1'b0, 1'b1, 16'h0021, 8'h00);
      req(1'b0, 1'b1, 16'h0022, 8'h00);
      rd(1'b1, 16'h0061, 8'hff);
      rd(1'b1, 16'h0062, 8'hc3);
      $display("test port f g access done");
      port_d_in = 8'h96;
      port_e_in = 8'he1;
      port_f_in = 8'h7e;
      port_g_in = 5'h15;
      repeat (2) @(posedge clock);
      rd(1'b1, 16'h0030, 8'h96);
      rd(1'b0, 16'h0010, 8'h96);
      rd(1'b0, 16'h0001, 8'he1);
      rd(1'b0, 16'h0000, 8'h7e);
      rd(1'b1, 16'h0063, 8'h15);
      req(1'b1, 1'b1, 16'h0021, 8'h00);
      rd(1'b1, 16'h0021, 8'he1);
      $display("test pin levels done");
      compat_mode = 1'b1;
      for (int i = 2; i < 6; i++) rd(1'b1, rw[i], 8'h00);
      chk(port_f_oe | {3'h0, port_g_oe}, 8'h00);
      req(1'b1, 1'b1, 16'h0062, 8'h00);
      rd(1'b1, 16'h0020, 8'h7e);
      compat_mode = 1'b0;
      rd(1'b1, 16'h0062, 8'hc3);
      chk(port_f_oe, 8'hff);
      $display("test legacy mode done");
      do_reset();
      rd(1'b1, 16'h0062, 8'h00);
      chk(port_e_out, 8'h00);
      $display("test second reset done");
      summarize();
   end
endmodule
